// >>> hw/isfl_pkg.sv
package isfl_pkg;
    // register byte addresses
    localparam logic [7:0] CTRL_ADDR     = 8'h60;
    localparam logic [7:0] IRQ_STAT_ADDR = 8'h64;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'h68;
    localparam logic [7:0] STATUS_ADDR   = 8'h70;
    localparam logic [7:0] TXLVL_ADDR    = 8'h74;
    localparam int         ADDR_W        = 8;

    // control register fields
    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_STALL_BIT = 1;
    localparam int CTRL_W         = 2;

    // status register fields
    localparam int ST_BUSY      = 0;
    localparam int ST_TX_ROOM   = 1;
    localparam int ST_TX_EMPTY  = 2;
    localparam int ST_RX_NE     = 3;
    localparam int ST_RX_FULL   = 4;
    localparam int ST_CTRL_BUSY = 5;
    localparam int ST_TGT_BUSY  = 6;
    localparam int ST_TX_STALL  = 7;
    localparam int ST_RX_STALL  = 8;
    localparam int ST_W         = 9;

    // interrupt event bits
    localparam int EV_ABORT      = 0;
    localparam int EV_BULK_ABORT = 1;
    localparam int EV_STALL_END  = 2;
    localparam int EV_SCL_DRY    = 3;
    localparam int EV_W          = 4;

    // transmit queue
    localparam int             CNT_W    = 3;
    localparam logic [2:0]     TX_DEPTH = 3'h7;
    localparam logic [2:0]     CNT_ONE  = 3'h1;
    localparam logic [2:0]     CNT_ZERO = 3'h0;

    // ahb encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;
endpackage

// >>> hw/isfl_status.sv
// Chosen here: the AHB-Lite slave port.
module isfl_status (
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rstn_i,
    // ahb-lite slave
    input  wire logic        hsel_i,
    input  wire logic [7:0]  haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic [31:0]      hrdata_o,
    // protocol engine side
    input  wire logic        ctrl_fsm_idle_i,
    input  wire logic        target_fsm_idle_i,
    input  wire logic        ctrl_writing_i,
    input  wire logic        last_cmd_stop_i,
    input  wire logic        rx_byte_waiting_i,
    input  wire logic        rx_queue_full_i,
    input  wire logic        rx_queue_nonempty_i,
    input  wire logic        tx_push_i,
    input  wire logic        tx_pop_i,
    input  wire logic        transmit_abort_event_i,
    input  wire logic        target_bulk_abort_i,
    // bus clock pin
    input  wire logic        scl_i,
    // outputs
    output logic             peripheral_enable_o,
    output logic             rx_full_bus_stall_option_o,
    output logic             tx_queue_full_o,
    output logic [2:0]       tx_queue_count_o,
    output logic             ctrl_rx_full_stall_o,
    output logic             ctrl_tx_empty_stall_o,
    output logic             irq_o
);
    logic [1:0]                     scl_sync_q, scl_sync_d;
    logic                           scl_prev_q, scl_prev_d;
    logic [isfl_pkg::CNT_W-1:0]     cnt_q, cnt_d;
    logic [isfl_pkg::CTRL_W-1:0]    ctrl_q, ctrl_d;
    logic [isfl_pkg::EV_W-1:0]      ev_q, ev_d, mask_q, mask_d, ev_set;
    logic                           stall_q, stall_d;
    logic                           wr_q, wr_d;
    logic [isfl_pkg::ADDR_W-1:0]    addr_q, addr_d;
    logic [31:0]                    rdata_q, rdata_d;
    logic [isfl_pkg::ST_W-1:0]      status;
    logic                           en, tx_empty, tx_full, push_ok, pop_ok;
    logic                           rx_stall, tx_stall, scl_fall, acc;

    assign en       = ctrl_q[isfl_pkg::CTRL_EN_BIT];
    assign tx_empty = (cnt_q == isfl_pkg::CNT_ZERO);
    assign tx_full  = (cnt_q == isfl_pkg::TX_DEPTH);
    // pushes into a full queue and pops from an empty one are dropped
    assign push_ok  = tx_push_i && !tx_full;
    assign pop_ok   = tx_pop_i && !tx_empty;
    assign scl_fall = scl_prev_q && !scl_sync_q[1];

    // a hold is only real while the engine keeps the clock line low
    assign rx_stall = en && ctrl_q[isfl_pkg::CTRL_STALL_BIT] && !ctrl_fsm_idle_i
                      && rx_queue_full_i && rx_byte_waiting_i
                      && !scl_sync_q[1];
    assign tx_stall = en && !ctrl_fsm_idle_i && ctrl_writing_i && tx_empty
                      && !last_cmd_stop_i && !scl_sync_q[1];

    always_comb
    begin
        status                         = '0;
        status[isfl_pkg::ST_RX_STALL]  = rx_stall;
        status[isfl_pkg::ST_TX_STALL]  = tx_stall;
        status[isfl_pkg::ST_TGT_BUSY]  = !target_fsm_idle_i;
        status[isfl_pkg::ST_CTRL_BUSY] = !ctrl_fsm_idle_i;
        status[isfl_pkg::ST_BUSY]      = !target_fsm_idle_i
                                         || !ctrl_fsm_idle_i;
        status[isfl_pkg::ST_RX_FULL]   = rx_queue_full_i;
        status[isfl_pkg::ST_RX_NE]     = en && rx_queue_nonempty_i;
        status[isfl_pkg::ST_TX_EMPTY]  = !en || tx_empty;
        status[isfl_pkg::ST_TX_ROOM]   = !en || !tx_full;
    end

    // events: status bits themselves never feed the interrupt
    always_comb
    begin
        ev_set                          = '0;
        ev_set[isfl_pkg::EV_ABORT]      = transmit_abort_event_i;
        ev_set[isfl_pkg::EV_BULK_ABORT] = target_bulk_abort_i;
        ev_set[isfl_pkg::EV_STALL_END]  = stall_q && !(rx_stall || tx_stall);
        ev_set[isfl_pkg::EV_SCL_DRY]    = scl_fall && en && tx_empty
                                          && !ctrl_fsm_idle_i;
    end

    assign acc = hsel_i && hready_i
                 && (htrans_i == isfl_pkg::HTRANS_NONSEQ
                     || htrans_i == isfl_pkg::HTRANS_SEQ);

    always_comb
    begin
        scl_sync_d = {scl_sync_q[0], scl_i};
        scl_prev_d = scl_sync_q[1];
        stall_d    = rx_stall || tx_stall;
        // clear has priority over push and pop
        if (!en || transmit_abort_event_i || target_bulk_abort_i)
            cnt_d = isfl_pkg::CNT_ZERO;
        else if (push_ok && !pop_ok)
            cnt_d = cnt_q + isfl_pkg::CNT_ONE;
        else if (pop_ok && !push_ok)
            cnt_d = cnt_q - isfl_pkg::CNT_ONE;
        else
            cnt_d = cnt_q;
        ctrl_d  = ctrl_q;
        mask_d  = mask_q;
        ev_d    = ev_q | ev_set;
        wr_d    = 1'b0;
        addr_d  = addr_q;
        rdata_d = '0;
        if (wr_q)
        begin
            if (addr_q == isfl_pkg::CTRL_ADDR)
                ctrl_d = hwdata_i[isfl_pkg::CTRL_W-1:0];
            if (addr_q == isfl_pkg::IRQ_MASK_ADDR)
                mask_d = hwdata_i[isfl_pkg::EV_W-1:0];
        end
        if (acc)
        begin
            wr_d   = hwrite_i;
            addr_d = haddr_i;
            if (!hwrite_i)
            begin
                unique case (haddr_i)
                    isfl_pkg::CTRL_ADDR:
                        rdata_d[isfl_pkg::CTRL_W-1:0] = ctrl_q;
                    isfl_pkg::IRQ_STAT_ADDR:
                    begin
                        rdata_d[isfl_pkg::EV_W-1:0] = ev_q;
                        // read clears, but a new event still lands
                        ev_d = ev_set;
                    end
                    isfl_pkg::IRQ_MASK_ADDR:
                        rdata_d[isfl_pkg::EV_W-1:0] = mask_q;
                    // plain read, nothing else moves
                    isfl_pkg::STATUS_ADDR:
                        rdata_d[isfl_pkg::ST_W-1:0] = status;
                    isfl_pkg::TXLVL_ADDR:
                        rdata_d[isfl_pkg::CNT_W-1:0] = cnt_q;
                    default:
                        rdata_d = '0;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            scl_sync_q <= 2'h3;
            scl_prev_q <= 1'b1;
            stall_q    <= 1'b0;
            cnt_q      <= isfl_pkg::CNT_ZERO;
            ctrl_q     <= '0;
            mask_q     <= '0;
            ev_q       <= '0;
            wr_q       <= 1'b0;
            addr_q     <= '0;
            rdata_q    <= '0;
        end
        else
        begin
            scl_sync_q <= scl_sync_d;
            scl_prev_q <= scl_prev_d;
            stall_q    <= stall_d;
            cnt_q      <= cnt_d;
            ctrl_q     <= ctrl_d;
            mask_q     <= mask_d;
            ev_q       <= ev_d;
            wr_q       <= wr_d;
            addr_q     <= addr_d;
            rdata_q    <= rdata_d;
        end
    end

    // zero wait states; hsize is not checked, word access is assumed
    assign hreadyout_o                = 1'b1;
    assign hresp_o                    = 1'b0;
    assign hrdata_o                   = rdata_q;
    assign peripheral_enable_o        = en;
    assign rx_full_bus_stall_option_o = ctrl_q[isfl_pkg::CTRL_STALL_BIT];
    assign tx_queue_full_o            = tx_full;
    assign tx_queue_count_o           = cnt_q;
    assign ctrl_rx_full_stall_o       = rx_stall;
    assign ctrl_tx_empty_stall_o      = tx_stall;
    assign irq_o                      = |(ev_q & mask_q);

    // checks
    rx_stall_opt_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        ctrl_rx_full_stall_o |-> rx_full_bus_stall_option_o
        && rx_queue_full_i && !ctrl_fsm_idle_i)
        else $error("rx stall without its cause");
    tx_stall_cause_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        ctrl_tx_empty_stall_o |-> tx_queue_count_o == 3'h0
        && !last_cmd_stop_i && ctrl_writing_i)
        else $error("tx stall without its cause");
    busy_or_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        status[isfl_pkg::ST_BUSY] == (status[isfl_pkg::ST_TGT_BUSY]
        || status[isfl_pkg::ST_CTRL_BUSY]))
        else $error("busy is not the or of both");
    busy_track_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $fell(ctrl_fsm_idle_i) |-> status[isfl_pkg::ST_CTRL_BUSY]
        && status[isfl_pkg::ST_BUSY])
        else $error("controller busy missed");
    tgt_busy_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        status[isfl_pkg::ST_TGT_BUSY] != target_fsm_idle_i)
        else $error("target busy wrong");
    rx_flags_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        status[isfl_pkg::ST_RX_FULL] == rx_queue_full_i)
        else $error("rx full flag wrong");
    tx_flags_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        en |-> status[isfl_pkg::ST_TX_EMPTY] == (cnt_q == 3'h0)
        && status[isfl_pkg::ST_TX_ROOM] == (cnt_q != 3'h7)
        && status[isfl_pkg::ST_RX_NE] == rx_queue_nonempty_i)
        else $error("queue flags wrong");
    count_step_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        en && tx_push_i && !tx_pop_i && cnt_q != 3'h7
        && !transmit_abort_event_i && !target_bulk_abort_i
        ##1 en |-> cnt_q == $past(cnt_q) + 3'h1)
        else $error("count did not step up");
    count_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        transmit_abort_event_i || target_bulk_abort_i || !en
        |=> cnt_q == 3'h0)
        else $error("count did not clear");
    disable_force_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !en |-> status[isfl_pkg::ST_TX_ROOM] && status[isfl_pkg::ST_TX_EMPTY]
        && !status[isfl_pkg::ST_RX_NE])
        else $error("disable did not force flags");
    level_read_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        acc && !hwrite_i && haddr_i == isfl_pkg::TXLVL_ADDR
        |=> hrdata_o == {29'h0, $past(cnt_q)})
        else $error("level read wrong");
    status_quiet_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        acc && !hwrite_i && haddr_i == isfl_pkg::STATUS_ADDR
        |=> ev_q == $past(ev_q | ev_set) && cnt_q == $past(cnt_d))
        else $error("status read had a side effect");

    full_cov: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
        tx_full ##1 pop_ok);
    stall_cov: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
        tx_stall ##[1:20] !tx_stall);
    irq_cov: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $rose(irq_o));
endmodule

// >>> dv/isfl_link_model.sv
// far side of the bus clock pin: devices on the wire
module isfl_link_model (
    // frame control from the bench
    input  wire logic frame_i,
    input  wire logic hold_low_i,
    // bus clock wire
    output logic      scl_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic scl_q;

    // odd start offset puts each link edge 7 ns after a core clock falling edge, clear of the rising one
    initial
    begin
        scl_q = 1'b1;
        #7;
        forever
        begin
            #160;
            scl_q = frame_i ? ~scl_q : 1'b1;
        end
    end

    // pull-up gives high between frames; a stretched low wins over it
    assign scl_o = hold_low_i ? 1'b0 : scl_q;
endmodule

// >>> dv/isfl_status_tb.sv
module isfl_status_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic        ref_clk_i, rstn_i, hsel_i, hwrite_i, en, opt, scl;
    logic [7:0]  haddr_i;
    logic [1:0]  htrans_i;
    logic [31:0] hwdata_i, hrdata_o, rdata;
    logic        hreadyout_o, hresp_o, ctrl_idle, tgt_idle, writing, stop;
    logic        rx_wait, rx_full, rx_ne, push, pop, abrt, bulk, frame, hold;
    logic        full_o, irq_o;
    logic [2:0]  cnt_o, exp_cnt;
    int          n_mismatch, checks_done;

    isfl_status isfl_status_inst (
        .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
        .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
        .ctrl_fsm_idle_i(ctrl_idle), .target_fsm_idle_i(tgt_idle),
        .ctrl_writing_i(writing), .last_cmd_stop_i(stop),
        .rx_byte_waiting_i(rx_wait), .rx_queue_full_i(rx_full),
        .rx_queue_nonempty_i(rx_ne), .tx_push_i(push), .tx_pop_i(pop),
        .transmit_abort_event_i(abrt), .target_bulk_abort_i(bulk),
        .scl_i(scl), .peripheral_enable_o(), .rx_full_bus_stall_option_o(),
        .tx_queue_full_o(full_o), .tx_queue_count_o(cnt_o),
        .ctrl_rx_full_stall_o(), .ctrl_tx_empty_stall_o(), .irq_o(irq_o));

    isfl_link_model isfl_link_model_inst (
        .frame_i(frame), .hold_low_i(hold), .scl_o(scl));

    initial
    begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end

    task automatic give_verdict;
        if (n_mismatch == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // hready sampled at the falling edge, half a cycle before the rising one, so no race with the slave
    task automatic wait_rdy;
        int i;
        i = 0;
        @(negedge ref_clk_i);
        while (hreadyout_o !== 1'b1 && i < 64)
        begin
            @(negedge ref_clk_i);
            i++;
        end
        if (i >= 64)
        begin
            n_mismatch++;
            give_verdict();
        end
        rdata = hrdata_o;
        @(posedge ref_clk_i);
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        hsel_i   <= 1'b1;
        haddr_i  <= a;
        hwrite_i <= wr;
        htrans_i <= isfl_pkg::HTRANS_NONSEQ;
        wait_rdy();
        htrans_i <= 2'h0;
        hsel_i   <= 1'b0;
        hwdata_i <= d;
        wait_rdy();
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rdata, exp);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    function automatic logic [31:0] exp_st();
        logic [31:0] s;
        s = 32'h0;
        s[5] = !ctrl_idle;
        s[6] = !tgt_idle;
        s[0] = s[5] | s[6];
        s[1] = !en || exp_cnt != isfl_pkg::TX_DEPTH;
        s[2] = !en || exp_cnt == 3'h0;
        s[3] = en && rx_ne;
        s[4] = rx_full;
        s[7] = en && writing && !stop && exp_cnt == 3'h0 && hold && !ctrl_idle;
        s[8] = en && opt && !ctrl_idle && rx_full && rx_wait && hold;
        return s;
    endfunction

    initial
    begin
        #400000;
        n_mismatch++;
        give_verdict();
    end

    initial
    begin
        {rstn_i, hsel_i, hwrite_i, haddr_i, htrans_i, hwdata_i} = '0;
        {writing, rx_wait, rx_full, rx_ne, push, pop, abrt, bulk} = '0;
        {frame, hold, en, opt, exp_cnt, n_mismatch, checks_done} = '0;
        {ctrl_idle, tgt_idle, stop} = 3'h7;
        tick(16);
        rstn_i <= 1'b1;
        tick(1);
        rd_chk(isfl_pkg::TXLVL_ADDR, 32'h0);
        push  <= 1'b1;
        rx_ne <= 1'b1;
        tick(1);
        push  <= 1'b0;
        rd_chk(isfl_pkg::TXLVL_ADDR, 32'h0);
        rd_chk(isfl_pkg::STATUS_ADDR, exp_st());
        bus(1'b1, isfl_pkg::CTRL_ADDR, 32'h1);
        en = 1'b1;
        rd_chk(isfl_pkg::STATUS_ADDR, exp_st());
        // one push more than the depth: the last one must be dropped
        push <= 1'b1;
        tick(8);
        push <= 1'b0;
        exp_cnt = isfl_pkg::TX_DEPTH;
        @(negedge ref_clk_i);
        chk({31'h0, full_o}, 32'h1);
        // bus requests start just after a rising edge
        @(posedge ref_clk_i);
        rd_chk(isfl_pkg::TXLVL_ADDR, 32'h7);
        rd_chk(isfl_pkg::STATUS_ADDR, exp_st());
        pop <= 1'b1;
        tick(1);
        push <= 1'b1;
        tick(1);
        {push, pop} <= 2'h0;
        exp_cnt = 3'h6;
        bus(1'b1, isfl_pkg::TXLVL_ADDR, 32'hffffffff);
        rd_chk(isfl_pkg::TXLVL_ADDR, 32'h6);
        rd_chk(8'h7c, 32'h0);
        {abrt, push} <= 2'h3;
        tick(1);
        {abrt, push} <= 2'h0;
        exp_cnt = 3'h0;
        rd_chk(isfl_pkg::TXLVL_ADDR, 32'h0);
        push <= 1'b1;
        tick(3);
        {push, bulk} <= 2'h1;
        tick(1);
        bulk <= 1'b0;
        rd_chk(isfl_pkg::TXLVL_ADDR, 32'h0);
        push <= 1'b1;
        tick(2);
        push <= 1'b0;
        bus(1'b1, isfl_pkg::CTRL_ADDR, 32'h0);
        en = 1'b0;
        // the count clears at the edge after the enable drops
        tick(1);
        rd_chk(isfl_pkg::TXLVL_ADDR, 32'h0);
        rx_full <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            {tgt_idle, ctrl_idle} <= 2'(i);
            tick(1);
            rd_chk(isfl_pkg::STATUS_ADDR, exp_st());
        end
        bus(1'b1, isfl_pkg::CTRL_ADDR, 32'h3);
        {en, opt} = 2'h3;
        bus(1'b0, isfl_pkg::IRQ_STAT_ADDR, 32'h0);
        bus(1'b1, isfl_pkg::IRQ_MASK_ADDR, 32'h1);
        abrt <= 1'b1;
        tick(1);
        abrt <= 1'b0;
        tick(3);
        chk({31'h0, irq_o}, 32'h1);
        bus(1'b0, isfl_pkg::IRQ_STAT_ADDR, 32'h0);
        chk(rdata & 32'h1, 32'h1);
        tick(1);
        chk({31'h0, irq_o}, 32'h0);
        bulk <= 1'b1;
        tick(1);
        bulk <= 1'b0;
        tick(3);
        chk({31'h0, irq_o}, 32'h0);
        bus(1'b0, isfl_pkg::IRQ_STAT_ADDR, 32'h0);
        chk(rdata & 32'h2, 32'h2);
        // stretched clock low with both stall causes present
        {ctrl_idle, rx_wait, writing, stop, hold} <= 5'h0d;
        tick(4);
        rd_chk(isfl_pkg::STATUS_ADDR, exp_st());
        chk({31'h0, irq_o}, 32'h0);
        bus(1'b1, isfl_pkg::CTRL_ADDR, 32'h1);
        opt = 1'b0;
        rd_chk(isfl_pkg::STATUS_ADDR, exp_st());
        push <= 1'b1;
        tick(1);
        push <= 1'b0;
        exp_cnt = 3'h1;
        rd_chk(isfl_pkg::STATUS_ADDR, exp_st());
        pop  <= 1'b1;
        tick(1);
        {pop, hold} <= 2'h0;
        exp_cnt = 3'h0;
        tick(4);
        bus(1'b0, isfl_pkg::IRQ_STAT_ADDR, 32'h0);
        chk(rdata & 32'h4, 32'h4);
        frame <= 1'b1;
        tick(40);
        frame <= 1'b0;
        tick(12);
        bus(1'b0, isfl_pkg::IRQ_STAT_ADDR, 32'h0);
        chk(rdata & 32'h8, 32'h8);
        give_verdict();
    end
endmodule
